/* File: include/prs_pkg.sv */
/*
  Constants, types and register map of the protection reaction sequencer.
  Assumes a 250 MHz reference clock and a 32-bit classic Wishbone master.
*/
package prs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int CTRL_PERIOD_US = 40;
  localparam int CTRL_PERIOD_CYCLES = (CTRL_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_REACTION  = 8'h00;
  localparam logic [7:0] OFS_LIMITED   = 8'h04;
  localparam logic [7:0] OFS_STAGE_MAP = 8'h08;
  localparam logic [7:0] OFS_WAIT      = 8'h0c;
  localparam logic [7:0] OFS_QWAIT     = 8'h10;
  localparam logic [7:0] OFS_LIMIT     = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_REACTION  = 32'h0000_0000;
  localparam logic [15:0] RST_LIMITED   = 16'h1fff;
  localparam logic [15:0] RST_STAGE_MAP = 16'h0000;
  localparam logic [15:0] RST_WAIT      = 16'h2710;
  localparam logic [15:0] RST_QWAIT     = 16'h0019;
  localparam logic [7:0]  RST_LIMIT     = 8'h03;
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_SOURCE_LSB = 4;
  localparam int ST_COUNT_LSB  = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    REACT_AUTO  = 2'b00,
    REACT_QUICK = 2'b01,
    REACT_LATCH = 2'b10,
    REACT_STOP  = 2'b11
  } reaction_t;

  typedef enum logic [2:0] {
    S_RUN      = 3'b000,
    S_SHUT     = 3'b001,
    S_WAIT     = 3'b010,
    S_RECHARGE = 3'b011,
    S_START1   = 3'b100,
    S_START2   = 3'b101,
    S_LATCH    = 3'b110,
    S_STOP     = 3'b111
  } seq_state_t;

  typedef struct packed {
    logic input_present;
    logic at_upper;
    logic at_lower;
  } supply_t;

  typedef struct packed {
    logic first_done;
    logic second_ok;
    logic second_done;
  } stage_status_t;

endpackage : prs_pkg

/* File: design/protection_reaction_sequencer.sv */
/*
  Protection reaction sequencer: shuts the two power stages down after a
  protection, then restarts, latches or stops as configured per source.
  Assumes protection flags and soft-start status come from logic on
  ref_clk, and supply comparators arrive asynchronously from pins.
*/
// The Wishbone interface to the registers and the register offsets were left to the implementer.
//
// Functional notes
// RULE1 - each source has its own reaction code
// RULE2 - related stage gate off within four periods
// RULE3 - other stage gates off four periods later; the code gates it off one ref_clk cycle after the related stage
// RULE4 - stop halts and enters serial parametrization
// RULE5 - restart includes supply recharge phase
// RULE6 - first stage restarts first with soft start
// RULE7 - second stage follows, waits for start conditions
// RULE8 - listed severe faults are restart limited
// RULE9 - limit reached means latch, not restart
// RULE10 - unlimited restart clears the restart counter
// RULE11 - auto restart waits restart time, then restarts
// RULE12 - quick restart waits quick time, then restarts
// RULE13 - startup source holds supply between thresholds
// RULE14 - recharge lengthens gap beyond wait time
// RULE15 - latch holds until input gone, supply low
// RULE16 - stop ceases switching, enters serial mode
// RULE17 - unsupplied stop drains supply, then restarts
// RULE18 - wait counted in control clock periods
`timescale 1ns/1ns
module protection_reaction_sequencer #(
  parameter int PERIOD_CYCLES = prs_pkg::CTRL_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output      logic [31:0]            wb_dat_o,
  output      logic                   wb_ack_o,
  // Protection sources and stage status
  input  wire logic [15:0]            prot_trig,
  input  wire prs_pkg::stage_status_t stage_status,
  // Supply comparators from pins
  input  wire prs_pkg::supply_t       supply_pin,
  // Power stage and supply control
  output      logic [1:0]             gate_drive_outputs,
  output      logic                   high_voltage_startup_source,
  output      logic                   serial_mode
);

  // ----------------------------------------------------------------------
  // Supply comparator synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  prs_pkg::supply_t supply;

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= supply_pin[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end
  assign supply = prs_pkg::supply_t'(sync_b);

  // ----------------------------------------------------------------------
  // Registers and Wishbone slave
  // ----------------------------------------------------------------------
  logic [31:0] reaction;
  logic [15:0] limited;
  logic [15:0] stage_map;
  logic [15:0] restart_wait_time;
  logic [15:0] quick_restart_wait_time;
  logic [7:0]  restart_limit_count;
  logic [7:0]  restart_count;
  logic [3:0]  src;
  prs_pkg::seq_state_t state;
  prs_pkg::seq_state_t next_state;

  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr  = wb_req & wb_we_i;
  wire [31:0] wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] status = {16'h0000, restart_count, src, 1'b0, state};
  wire [31:0] rd_mux =
      (wb_adr_i == prs_pkg::OFS_REACTION)  ? reaction :
      (wb_adr_i == prs_pkg::OFS_LIMITED)   ? {16'h0000, limited} :
      (wb_adr_i == prs_pkg::OFS_STAGE_MAP) ? {16'h0000, stage_map} :
      (wb_adr_i == prs_pkg::OFS_WAIT)      ? {16'h0000, restart_wait_time} :
      (wb_adr_i == prs_pkg::OFS_QWAIT)     ? {16'h0000, quick_restart_wait_time} :
      (wb_adr_i == prs_pkg::OFS_LIMIT)     ? {24'h000000, restart_limit_count} :
      (wb_adr_i == prs_pkg::OFS_STATUS)    ? status : 32'h0000_0000;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reaction                <= prs_pkg::RST_REACTION;
      limited                 <= prs_pkg::RST_LIMITED;
      stage_map               <= prs_pkg::RST_STAGE_MAP;
      restart_wait_time       <= prs_pkg::RST_WAIT;
      quick_restart_wait_time <= prs_pkg::RST_QWAIT;
      restart_limit_count     <= prs_pkg::RST_LIMIT;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        prs_pkg::OFS_REACTION:  reaction <= merge(reaction, wmask, wb_dat_i); // RULE1
        prs_pkg::OFS_LIMITED:
          limited <= 16'(merge({16'h0000, limited}, wmask, wb_dat_i)); // RULE8
        prs_pkg::OFS_STAGE_MAP: stage_map <= 16'(merge({16'h0000, stage_map}, wmask, wb_dat_i));
        prs_pkg::OFS_WAIT:
          restart_wait_time <= 16'(merge({16'h0000, restart_wait_time}, wmask, wb_dat_i));
        prs_pkg::OFS_QWAIT:
          quick_restart_wait_time <=
            16'(merge({16'h0000, quick_restart_wait_time}, wmask, wb_dat_i));
        prs_pkg::OFS_LIMIT:
          restart_limit_count <= 8'(merge({24'h000000, restart_limit_count}, wmask, wb_dat_i));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control period tick and trigger selection
  // ----------------------------------------------------------------------
  logic [15:0] period_cnt;
  wire         tick = (period_cnt == 16'(PERIOD_CYCLES - 1));
  // The period count restarts with each shutdown, so a wait of N periods never ends early.
  wire         period_clear = tick || (state == prs_pkg::S_SHUT); // RULE14

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) period_cnt <= 16'h0000;
    else     period_cnt <= period_clear ? 16'h0000 : period_cnt + 16'h0001;
  end

  function automatic logic [3:0] first_set(input logic [15:0] v);
    first_set = 4'h0;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) first_set = 4'(k);
    end
  endfunction : first_set

  wire       active   = (state == prs_pkg::S_RUN) || (state == prs_pkg::S_START1) ||
                        (state == prs_pkg::S_START2);
  wire       trig_hit = active && (prot_trig != 16'h0000);
  wire [3:0] hit_src  = first_set(prot_trig);
  wire       hit_stg  = stage_map[hit_src];

  // ----------------------------------------------------------------------
  // Reaction decision
  // ----------------------------------------------------------------------
  prs_pkg::reaction_t src_react;
  assign src_react = prs_pkg::reaction_t'(reaction[{src, 1'b0} +: 2]);
  wire is_limited  = limited[src];
  wire limit_hit   = is_limited && (restart_count >= restart_limit_count);
  wire is_restart  = (src_react == prs_pkg::REACT_AUTO) || (src_react == prs_pkg::REACT_QUICK);
  wire go_latch    = (src_react == prs_pkg::REACT_LATCH) || (is_restart && limit_hit);
  wire [15:0] wait_load = (src_react == prs_pkg::REACT_QUICK) ? quick_restart_wait_time
                                                              : restart_wait_time;
  logic [15:0] wait_cnt;
  wire         wait_done = (wait_cnt == 16'h0000);
  wire         released  = !supply.input_present && supply.at_lower;

  always_comb begin
    next_state = state;
    unique case (state)
      prs_pkg::S_RUN, prs_pkg::S_START1, prs_pkg::S_START2: begin
        if (trig_hit)
          next_state = prs_pkg::S_SHUT;
        else if (state == prs_pkg::S_START1 && stage_status.first_done)
          next_state = prs_pkg::S_START2; // RULE6
        else if (state == prs_pkg::S_START2 && stage_status.second_done && gate_drive_outputs[1])
          next_state = prs_pkg::S_RUN;
      end
      prs_pkg::S_SHUT: begin
        if (src_react == prs_pkg::REACT_STOP) next_state = prs_pkg::S_STOP; // RULE4
        else if (go_latch)                    next_state = prs_pkg::S_LATCH; // RULE9
        else                                  next_state = prs_pkg::S_WAIT;
      end
      prs_pkg::S_WAIT:
        if (wait_done) next_state = prs_pkg::S_RECHARGE; // RULE14
      prs_pkg::S_RECHARGE:
        if (supply.at_upper && supply.input_present) next_state = prs_pkg::S_START1; // RULE5
      prs_pkg::S_LATCH:
        if (released) next_state = prs_pkg::S_RECHARGE; // RULE15
      prs_pkg::S_STOP:
        if (supply.at_lower) next_state = prs_pkg::S_RECHARGE; // RULE17
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer state, counters and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= prs_pkg::S_RECHARGE;
      src   <= 4'h0;
    end else begin
      state <= next_state;
      if (trig_hit) src <= hit_src;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_count <= 8'h00;
      wait_cnt      <= 16'h0000;
    end else begin
      if (state == prs_pkg::S_SHUT && is_restart) begin
        if (!is_limited)     restart_count <= 8'h00; // RULE10
        else if (!limit_hit) restart_count <= restart_count + 8'h01; // RULE9
      end
      if (state == prs_pkg::S_SHUT)
        wait_cnt <= wait_load; // RULE11 RULE12 RULE18
      else if (state == prs_pkg::S_WAIT && tick && !wait_done)
        wait_cnt <= wait_cnt - 16'h0001; // RULE18
    end
  end

  wire hold_band = (state == prs_pkg::S_WAIT) || (state == prs_pkg::S_LATCH);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_drive_outputs          <= 2'b00;
      high_voltage_startup_source <= 1'b1;
      serial_mode                 <= 1'b0;
    end else begin
      if (trig_hit)
        gate_drive_outputs[hit_stg] <= 1'b0; // RULE2
      else if (state == prs_pkg::S_SHUT)
        gate_drive_outputs <= 2'b00; // RULE3
      else if (state == prs_pkg::S_START1)
        gate_drive_outputs[0] <= 1'b1; // RULE6
      else if (state == prs_pkg::S_START2 && stage_status.second_ok)
        gate_drive_outputs[1] <= 1'b1; // RULE7
      if (hold_band || state == prs_pkg::S_RECHARGE) begin
        if (supply.at_upper)      high_voltage_startup_source <= 1'b0; // RULE13
        else if (supply.at_lower) high_voltage_startup_source <= 1'b1; // RULE13
        else if (state == prs_pkg::S_RECHARGE) high_voltage_startup_source <= 1'b1;
      end else begin
        high_voltage_startup_source <= 1'b0;
      end
      serial_mode <= (next_state == prs_pkg::S_STOP); // RULE16
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence shut_entry;
    trig_hit ##1 (state == prs_pkg::S_SHUT);
  endsequence

  a_related_stage_off: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    trig_hit |=> !gate_drive_outputs[$past(hit_stg)])
    else $error("related stage gate still on after trigger");
  a_all_stages_off: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    shut_entry |=> (gate_drive_outputs == 2'b00))
    else $error("gates not all off after shutdown");
  a_stop_serial_mode: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    (state == prs_pkg::S_SHUT && src_react == prs_pkg::REACT_STOP)
      |=> serial_mode && (state == prs_pkg::S_STOP) && gate_drive_outputs == 2'b00)
    else $error("stop reaction did not enter serial mode");
  a_first_stage_first: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    $rose(gate_drive_outputs[1]) |-> gate_drive_outputs[0])
    else $error("second stage enabled before first");
  a_second_held_back: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    (state == prs_pkg::S_START2 && !stage_status.second_ok && !gate_drive_outputs[1])
      |=> !gate_drive_outputs[1])
    else $error("second stage enabled without start conditions");
  a_limit_latches: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    (state == prs_pkg::S_SHUT && is_restart && limit_hit) |=> (state == prs_pkg::S_LATCH))
    else $error("restart limit reached but not latched");
  a_counter_cleared: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    (state == prs_pkg::S_SHUT && is_restart && !is_limited) |=> (restart_count == 8'h00))
    else $error("unlimited restart did not clear counter");
  a_wait_loaded: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    (state == prs_pkg::S_SHUT && src_react == prs_pkg::REACT_AUTO && !limit_hit)
      |=> (state == prs_pkg::S_WAIT) && (wait_cnt == $past(restart_wait_time)))
    else $error("restart wait not loaded with restart time");
  a_quick_loaded: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    (state == prs_pkg::S_SHUT && src_react == prs_pkg::REACT_QUICK && !limit_hit)
      |=> (wait_cnt == $past(quick_restart_wait_time)))
    else $error("quick wait not loaded with quick time");
  a_supply_band: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    (hold_band && supply.at_upper) |=> !high_voltage_startup_source)
    else $error("startup source on above upper threshold");
  a_wait_then_recharge: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (state == prs_pkg::S_WAIT && wait_done) |=> (state == prs_pkg::S_RECHARGE) ##1
      (gate_drive_outputs == 2'b00))
    else $error("restart skipped the recharge phase");
  a_latch_holds: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    (state == prs_pkg::S_LATCH && !released) |=> (state == prs_pkg::S_LATCH) &&
      (gate_drive_outputs == 2'b00))
    else $error("latch left without power removal");

endmodule : protection_reaction_sequencer

/* File: dv/supply_stage_model.sv */
/*
  Behavioural far side of the sequencer: supply rail, mains and the soft
  starts of both power stages.
  Assumes it shares ref_clk and rst with the sequencer.
*/
`timescale 1ns/1ns
module supply_stage_model (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Sequencer outputs
  input  wire logic [1:0]             gate_drive_outputs,
  input  wire logic                   high_voltage_startup_source,
  // Bench controls
  input  wire logic                   mains_on,
  input  wire logic                   ext_supply,
  input  wire logic                   allow_second,
  // Feedback to the sequencer
  output      prs_pkg::stage_status_t stage_status,
  output      prs_pkg::supply_t       supply_pin
);
  // ----
  // Supply rail
  // ----
  // The rail charges from the startup source with mains present, from an
  // outside supply, or from the aux winding while the first stage runs.
  logic [5:0] level;
  logic [2:0] run_first;
  logic [2:0] run_second;
  wire  logic feed;
  assign feed = (high_voltage_startup_source && mains_on) || ext_supply ||
                gate_drive_outputs[0];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level      <= 6'h00;
      run_first  <= 3'h0;
      run_second <= 3'h0;
    end else begin
      level      <= feed ? level + 6'(level != 6'h28) : level - 6'(level != 6'h00);
      run_first  <= gate_drive_outputs[0] ? run_first + 3'(run_first != 3'h7) : 3'h0;
      run_second <= gate_drive_outputs[1] ? run_second + 3'(run_second != 3'h7) : 3'h0;
    end
  end
  // ----
  // Comparators and soft-start status
  // ----
  assign supply_pin   = {mains_on, level >= 6'h20, level <= 6'h08};
  assign stage_status = {run_first == 3'h7, allow_second, run_second == 3'h7};
endmodule : supply_stage_model

/* File: dv/protection_reaction_sequencer_bench.sv */
/*
  Self-checking bench for the protection reaction sequencer.
  Assumes the supply and stage model beside it and a 4-cycle period.
*/
`timescale 1ns/1ns
module protection_reaction_sequencer_bench;
  localparam int P = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat;
  logic [15:0] prot_trig = 16'h0000;
  logic mains_on = 1'b1, ext_supply = 1'b0, allow_second = 1'b0;
  logic [1:0] gates;
  logic hv, serial_mode;
  prs_pkg::stage_status_t stage_status;
  prs_pkg::supply_t supply_pin;
  int fails = 0;
  int num_checks = 0;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [31:0] rstv [7] = '{32'h0, 32'h1fff, 32'h0, 32'h2710, 32'h19, 32'h3, 32'h0};

  always #2 ref_clk = ~ref_clk;

  protection_reaction_sequencer #(.PERIOD_CYCLES(P)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .prot_trig(prot_trig), .stage_status(stage_status),
    .supply_pin(supply_pin), .gate_drive_outputs(gates),
    .high_voltage_startup_source(hv), .serial_mode(serial_mode));

  supply_stage_model far_u (
    .ref_clk(ref_clk), .rst(rst), .gate_drive_outputs(gates),
    .high_voltage_startup_source(hv), .mains_on(mains_on), .ext_supply(ext_supply),
    .allow_second(allow_second), .stage_status(stage_status), .supply_pin(supply_pin));

  // ----
  // Report
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ----
  // Bus and wait helpers
  // ----
  // Ack and read data are taken at the rising edge that samples ack high,
  // and the request is released at that same edge.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    chk("bus ack", 32'h1, 32'(wb_ack));
    if (n >= 50) wrap_up();
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(what, exp, v);
  endtask : rd_chk

  task automatic wait_gates(input logic [1:0] exp, output int n);
    n = 0;
    while (gates !== exp && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("gate drive outputs", 32'(exp), 32'(gates));
    if (n >= 2000) wrap_up();
  endtask : wait_gates

  task automatic wait_state(input logic [2:0] s, output logic [31:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, prs_pkg::OFS_STATUS, 32'h0, v);
      n++;
    end while (v[2:0] !== s && n < 400);
    chk("status state", 32'(s), 32'(v[2:0]));
    if (n >= 400) wrap_up();
  endtask : wait_state

  // Trigger one source for one cycle and watch the two shutdown steps.
  task automatic fire(input int idx, input logic stage);
    @(posedge ref_clk);
    prot_trig <= 16'h0001 << idx;
    @(posedge ref_clk);
    prot_trig <= 16'h0000;
    @(negedge ref_clk);
    chk("related gate", 32'h0, 32'(gates[stage]));
    chk("other gate", 32'h1, 32'(gates[!stage]));
    @(negedge ref_clk);
    chk("all gates", 32'h0, 32'(gates));
  endtask : fire

  task automatic leave_latch();
    logic [31:0] v;
    int on_n, off_n, bad, n;
    on_n = 0;
    off_n = 0;
    bad = 0;
    repeat (120) begin
      @(negedge ref_clk);
      if (hv) on_n++;
      else off_n++;
      if (gates !== 2'b00) bad++;
    end
    chk("gates in latch", 32'h0, 32'(bad));
    chk("source switched on", 32'h1, 32'(on_n > 0 && off_n > 0));
    wait_state(3'h6, v);
    @(posedge ref_clk);
    mains_on <= 1'b0;
    wait_state(3'h3, v);
    @(posedge ref_clk);
    mains_on <= 1'b1;
    wait_gates(2'b11, n);
  endtask : leave_latch

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] v;
    int gap, bad;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd_chk("reset value", ofs[i], rstv[i]);
    xfer(1'b1, 8'h20, 32'hffff_ffff, v);
    rd_chk("unmapped", 8'h20, 32'h0);
    xfer(1'b1, prs_pkg::OFS_REACTION, 32'hd200_0000, v);
    xfer(1'b1, prs_pkg::OFS_STAGE_MAP, 32'h0000_2000, v);
    xfer(1'b1, prs_pkg::OFS_WAIT, 32'h5, v);
    xfer(1'b1, prs_pkg::OFS_QWAIT, 32'h1, v);
    xfer(1'b1, prs_pkg::OFS_LIMIT, 32'h1, v);
    rd_chk("reaction", prs_pkg::OFS_REACTION, 32'hd200_0000);
    rd_chk("restart limit", prs_pkg::OFS_LIMIT, 32'h1);
    $display("test registers done");
    wait_gates(2'b01, gap);
    bad = 0;
    repeat (20) begin
      @(negedge ref_clk);
      if (gates !== 2'b01) bad++;
    end
    chk("second stage held", 32'h0, 32'(bad));
    @(posedge ref_clk);
    allow_second <= 1'b1;
    wait_gates(2'b11, gap);
    wait_state(3'h0, v);
    $display("test startup done");
    fire(0, 1'b0);
    wait_gates(2'b11, gap);
    wait_state(3'h0, v);
    chk("restart count", 32'h1, 32'(v[15:8]));
    fire(13, 1'b1);
    wait_gates(2'b01, gap);
    chk("auto gap", 32'h1, 32'(gap > 5 * P));
    wait_gates(2'b11, gap);
    wait_state(3'h0, v);
    chk("restart count", 32'h0, 32'(v[15:8]));
    fire(14, 1'b0);
    wait_gates(2'b01, gap);
    chk("quick gap", 32'h1, 32'(gap > P && gap < 5 * P));
    wait_gates(2'b11, gap);
    wait_state(3'h0, v);
    $display("test restarts done");
    fire(0, 1'b0);
    wait_gates(2'b11, gap);
    wait_state(3'h0, v);
    fire(0, 1'b0);
    wait_state(3'h6, v);
    leave_latch();
    wait_state(3'h0, v);
    fire(12, 1'b0);
    wait_state(3'h6, v);
    leave_latch();
    wait_state(3'h0, v);
    $display("test latch done");
    ext_supply <= 1'b1;
    fire(15, 1'b0);
    wait_state(3'h7, v);
    chk("serial mode", 32'h1, 32'(serial_mode));
    repeat (60) @(posedge ref_clk);
    wait_state(3'h7, v);
    ext_supply <= 1'b0;
    wait_gates(2'b11, gap);
    chk("serial mode", 32'h0, 32'(serial_mode));
    $display("test stop done");
    wrap_up();
  end
endmodule : protection_reaction_sequencer_bench
